// >>> src/mpfo_pkg.sv
package mpfo_pkg;
   // ==========================================================
   // Register byte addresses
   localparam logic [7:0] OFS_CON1   = 8'h00;
   localparam logic [7:0] OFS_FLTA   = 8'h04;
   localparam logic [7:0] OFS_FLTB   = 8'h08;
   localparam logic [7:0] OFS_OVD    = 8'h0C;
   localparam logic [7:0] OFS_DC1    = 8'h10;
   localparam logic [7:0] OFS_DC2    = 8'h14;
   localparam logic [7:0] OFS_DC3    = 8'h18;
   localparam logic [7:0] OFS_KEY    = 8'h1C;
   localparam logic [7:0] OFS_ACT1   = 8'h20;
   localparam logic [7:0] OFS_ACT2   = 8'h24;
   localparam logic [7:0] OFS_ACT3   = 8'h28;
   localparam logic [7:0] OFS_STAT   = 8'h2C;
   // ==========================================================
   // Field positions and masks
   localparam int         CON1_UPD_OFF  = 0;
   localparam int         CON1_OVR_SYNC = 1;
   localparam int         CON1_UPD_NOW  = 2;
   localparam logic [15:0] CON1_MASK = 16'h0F07;
   localparam logic [15:0] FLT_MASK  = 16'h3F87;
   localparam int         FLT_MODE   = 7;
   localparam int         FLT_OV_LO  = 8;
   localparam logic [15:0] OVD_MASK  = 16'h3F3F;
   localparam int         OVD_GEN_LO = 8;
   // ==========================================================
   // Reset values
   localparam logic [15:0] CON1_RST  = 16'h0000;
   localparam logic [15:0] FLT_RST   = 16'h0007;
   localparam logic [15:0] OVD_RST   = 16'h3F00;
   localparam logic [15:0] DC_RST    = 16'h0000;
   // ==========================================================
   // Unlock sequence, values arbitrary
   localparam logic [15:0] KEY_FIRST  = 16'hABCD;
   localparam logic [15:0] KEY_SECOND = 16'h4321;
endpackage : mpfo_pkg

// >>> src/mpfo_reg16.sv
`timescale 1ns/100ps
module mpfo_reg16 #(
   parameter logic [15:0] RST  = 16'h0000,
   parameter logic [15:0] MASK = 16'hFFFF
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        we,
   input  wire logic [15:0] wdata,
   output logic      [15:0] q
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= RST & MASK;
      end else if (we) begin
         q <= wdata & MASK;
      end
   end
endmodule : mpfo_reg16

// >>> src/mpfo_top.sv
`timescale 1ns/100ps
module mpfo_top #(
   parameter int DW = 16
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        write_lock_config,
   input  wire logic        time_base_tick,
   input  wire logic [2:0]  gen_high,
   input  wire logic [2:0]  gen_low,
   input  wire logic        fault_a_input_pin_n,
   input  wire logic        fault_b_input_pin_n,
   output logic      [2:0]  high_side_output,
   output logic      [2:0]  low_side_output,
   output logic      [15:0] duty_value_one,
   output logic      [15:0] duty_value_two,
   output logic      [15:0] duty_value_three
);
   // Register file and read mux are built for 16-bit words only
   if (DW != 16) begin : g_dw_check
      $error("mpfo_top: DW must be 16");
   end

   // ==========================================================
   // Bus decode
   logic        wr_en;
   logic        known;
   logic [15:0] wd;
   assign wr_en = psel && penable && pwrite;
   assign wd    = pwdata[15:0];
   always_comb begin
      case (paddr)
         mpfo_pkg::OFS_CON1, mpfo_pkg::OFS_FLTA, mpfo_pkg::OFS_FLTB,
         mpfo_pkg::OFS_OVD, mpfo_pkg::OFS_DC1, mpfo_pkg::OFS_DC2,
         mpfo_pkg::OFS_DC3, mpfo_pkg::OFS_KEY, mpfo_pkg::OFS_ACT1,
         mpfo_pkg::OFS_ACT2, mpfo_pkg::OFS_ACT3, mpfo_pkg::OFS_STAT: known = 1'b1;
         default: known = 1'b0;
      endcase
   end

   // ==========================================================
   // Unlock sequencer
   typedef enum logic [1:0] {MPFO_LOCKED, MPFO_HALF, MPFO_OPEN} mpfo_key_t;
   mpfo_key_t   key_reg;
   logic [15:0] key_val_reg;
   logic        prot_hit;
   logic        prot_ok;
   assign prot_hit = wr_en && (paddr == mpfo_pkg::OFS_CON1 || paddr == mpfo_pkg::OFS_FLTA ||
                               paddr == mpfo_pkg::OFS_FLTB);
   assign prot_ok  = !write_lock_config || (key_reg == MPFO_OPEN);

   // Unlock lasts for the next write only, to any register, then relocks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_reg <= MPFO_LOCKED;
      end else if (wr_en && paddr == mpfo_pkg::OFS_KEY) begin
         if (wd == mpfo_pkg::KEY_FIRST) begin
            key_reg <= MPFO_HALF;
         end else if (wd == mpfo_pkg::KEY_SECOND && key_reg == MPFO_HALF) begin
            key_reg <= MPFO_OPEN;
         end else begin
            key_reg <= MPFO_LOCKED;
         end
      end else if (wr_en) begin
         key_reg <= MPFO_LOCKED;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_val_reg <= 16'h0000;
      end else if (wr_en && paddr == mpfo_pkg::OFS_KEY) begin
         key_val_reg <= wd;
      end
   end

   // ==========================================================
   // Register file
   logic [15:0] con1;
   logic [15:0] flta;
   logic [15:0] fltb;
   logic [15:0] ovd;
   logic [15:0] dc1;
   logic [15:0] dc2;
   logic [15:0] dc3;

   mpfo_reg16 #(.RST(mpfo_pkg::CON1_RST), .MASK(mpfo_pkg::CON1_MASK)) u_con1 (
      .pclk(pclk), .presetn(presetn),
      .we(prot_hit && prot_ok && paddr == mpfo_pkg::OFS_CON1), .wdata(wd), .q(con1));
   mpfo_reg16 #(.RST(mpfo_pkg::FLT_RST), .MASK(mpfo_pkg::FLT_MASK)) u_flta (
      .pclk(pclk), .presetn(presetn),
      .we(prot_hit && prot_ok && paddr == mpfo_pkg::OFS_FLTA), .wdata(wd), .q(flta));
   mpfo_reg16 #(.RST(mpfo_pkg::FLT_RST), .MASK(mpfo_pkg::FLT_MASK)) u_fltb (
      .pclk(pclk), .presetn(presetn),
      .we(prot_hit && prot_ok && paddr == mpfo_pkg::OFS_FLTB), .wdata(wd), .q(fltb));
   mpfo_reg16 #(.RST(mpfo_pkg::OVD_RST), .MASK(mpfo_pkg::OVD_MASK)) u_ovd (
      .pclk(pclk), .presetn(presetn),
      .we(wr_en && paddr == mpfo_pkg::OFS_OVD), .wdata(wd), .q(ovd));
   mpfo_reg16 #(.RST(mpfo_pkg::DC_RST), .MASK(16'hFFFF)) u_dc1 (
      .pclk(pclk), .presetn(presetn),
      .we(wr_en && paddr == mpfo_pkg::OFS_DC1), .wdata(wd), .q(dc1));
   mpfo_reg16 #(.RST(mpfo_pkg::DC_RST), .MASK(16'hFFFF)) u_dc2 (
      .pclk(pclk), .presetn(presetn),
      .we(wr_en && paddr == mpfo_pkg::OFS_DC2), .wdata(wd), .q(dc2));
   mpfo_reg16 #(.RST(mpfo_pkg::DC_RST), .MASK(16'hFFFF)) u_dc3 (
      .pclk(pclk), .presetn(presetn),
      .we(wr_en && paddr == mpfo_pkg::OFS_DC3), .wdata(wd), .q(dc3));

   // ==========================================================
   // Active duty transfer
   logic dc_xfer;
   assign dc_xfer = !con1[mpfo_pkg::CON1_UPD_OFF] &&
                    (con1[mpfo_pkg::CON1_UPD_NOW] || time_base_tick);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_value_one   <= mpfo_pkg::DC_RST;
         duty_value_two   <= mpfo_pkg::DC_RST;
         duty_value_three <= mpfo_pkg::DC_RST;
      end else if (dc_xfer) begin
         duty_value_one   <= dc1;
         duty_value_two   <= dc2;
         duty_value_three <= dc3;
      end
   end

   // ==========================================================
   // Override shadow
   logic [15:0] ovd_act_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovd_act_reg <= mpfo_pkg::OVD_RST;
      end else if (!con1[mpfo_pkg::CON1_OVR_SYNC] || time_base_tick) begin
         ovd_act_reg <= ovd;
      end
   end

   // ==========================================================
   // Fault capture; pins are active low
   logic fa_act;
   logic fb_act;
   logic fa_latch_reg;
   logic fb_latch_reg;
   assign fa_act = !fault_a_input_pin_n;
   assign fb_act = !fault_b_input_pin_n;

   // Latched faults clear on a time base tick once the pin is released
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fa_latch_reg <= 1'b0;
         fb_latch_reg <= 1'b0;
      end else begin
         if (fa_act && !flta[mpfo_pkg::FLT_MODE]) begin
            fa_latch_reg <= 1'b1;
         end else if (time_base_tick && (flta[mpfo_pkg::FLT_MODE] || !fa_act)) begin
            fa_latch_reg <= 1'b0;
         end
         if (fb_act && !fltb[mpfo_pkg::FLT_MODE]) begin
            fb_latch_reg <= 1'b1;
         end else if (time_base_tick && (fltb[mpfo_pkg::FLT_MODE] || !fb_act)) begin
            fb_latch_reg <= 1'b0;
         end
      end
   end

   logic fa_on;
   logic fb_on;
   assign fa_on = fa_act || fa_latch_reg;
   assign fb_on = fb_act || fb_latch_reg;

   // ==========================================================
   // Output selection; fault A has priority over fault B
   logic [2:0] hi_next;
   logic [2:0] lo_next;
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (ovd_act_reg[mpfo_pkg::OVD_GEN_LO + 2*i + 1]) begin
            hi_next[i] = gen_high[i];
         end else begin
            hi_next[i] = ovd_act_reg[2*i + 1];
         end
         if (ovd_act_reg[mpfo_pkg::OVD_GEN_LO + 2*i]) begin
            lo_next[i] = gen_low[i];
         end else begin
            lo_next[i] = ovd_act_reg[2*i];
         end
         if (fb_on && fltb[i]) begin
            hi_next[i] = fltb[mpfo_pkg::FLT_OV_LO + 2*i + 1];
            lo_next[i] = fltb[mpfo_pkg::FLT_OV_LO + 2*i];
         end
         if (fa_on && flta[i]) begin
            hi_next[i] = flta[mpfo_pkg::FLT_OV_LO + 2*i + 1];
            lo_next[i] = flta[mpfo_pkg::FLT_OV_LO + 2*i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         high_side_output <= 3'h0;
         low_side_output  <= 3'h0;
      end else begin
         high_side_output <= hi_next;
         low_side_output  <= lo_next;
      end
   end

   // ==========================================================
   // APB answer: zero wait states, registered read data
   logic [15:0] rd;
   always_comb begin
      case (paddr)
         mpfo_pkg::OFS_CON1: rd = con1;
         mpfo_pkg::OFS_FLTA: rd = flta;
         mpfo_pkg::OFS_FLTB: rd = fltb;
         mpfo_pkg::OFS_OVD:  rd = ovd;
         mpfo_pkg::OFS_DC1:  rd = dc1;
         mpfo_pkg::OFS_DC2:  rd = dc2;
         mpfo_pkg::OFS_DC3:  rd = dc3;
         mpfo_pkg::OFS_KEY:  rd = key_val_reg;
         mpfo_pkg::OFS_ACT1: rd = duty_value_one;
         mpfo_pkg::OFS_ACT2: rd = duty_value_two;
         mpfo_pkg::OFS_ACT3: rd = duty_value_three;
         mpfo_pkg::OFS_STAT: rd = {11'h000, key_reg == MPFO_OPEN, fb_on, fa_on,
                                   fb_latch_reg, fa_latch_reg};
         default:            rd = 16'h0000;
      endcase
   end

   // pready is registered: it rises at the edge that ends the setup cycle, so it is high in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !known;
         prdata  <= (psel && !penable) ? {16'h0000, rd} : 32'h0000_0000;
      end
   end
endmodule : mpfo_top

// >>> verif/mpfo_top_props.sv
`timescale 1ns/100ps
module mpfo_top_props (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        write_lock_config,
   input wire logic        time_base_tick,
   input wire logic [2:0]  gen_high,
   input wire logic [2:0]  gen_low,
   input wire logic        fault_a_input_pin_n,
   input wire logic        fault_b_input_pin_n,
   input wire logic [2:0]  high_side_output,
   input wire logic [2:0]  low_side_output,
   input wire logic [15:0] duty_value_one
);
   // =========
   // Shadow state
   logic [15:0] con_reg;
   logic [15:0] ovd_reg;
   logic [15:0] ovd_seen_reg;
   logic [15:0] dc_reg;
   logic        quiet_reg;
   logic        wr;
   logic        exp_h;
   logic        exp_l;
   assign wr = psel && penable && pready && pwrite;
   assign exp_h = ovd_seen_reg[9] ? gen_high[0] : ovd_seen_reg[1];
   assign exp_l = ovd_seen_reg[12] ? gen_low[2] : ovd_seen_reg[4];
   // Override value in force: follows the register each cycle, or only on a tick when synced
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovd_seen_reg <= 16'h3F00;
      end else if (!con_reg[1] || time_base_tick) begin
         ovd_seen_reg <= ovd_reg;
      end
   end
   // Control shadow is only trusted while the lock is off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         con_reg <= 16'h0000;
         ovd_reg <= 16'h3F00;
         dc_reg <= 16'h0000;
      end else if (wr) begin
         if (paddr == mpfo_pkg::OFS_CON1 && !write_lock_config) con_reg <= pwdata[15:0];
         if (paddr == mpfo_pkg::OFS_OVD) ovd_reg <= pwdata[15:0];
         if (paddr == mpfo_pkg::OFS_DC1) dc_reg <= pwdata[15:0];
      end
   end
   // A fault is only known cleared after a tick with both pins released
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) quiet_reg <= 1'b0;
      else if (!fault_a_input_pin_n || !fault_b_input_pin_n) quiet_reg <= 1'b0;
      else if (time_base_tick) quiet_reg <= 1'b1;
   end
   // =========
   // Properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   sequence s_calm;
      quiet_reg && fault_a_input_pin_n && fault_b_input_pin_n;
   endsequence
   a_ready_setup: assert property (s_setup |=> s_access)
      else $error("pready missing after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_duty_hold: assert property (!con_reg[2] && !time_base_tick |=> $stable(duty_value_one))
      else $error("duty changed off the time base");
   a_update_block: assert property (con_reg[0] |=> $stable(duty_value_one))
      else $error("duty changed while updates disabled");
   a_tick_load: assert property (!con_reg[0] && time_base_tick |=> duty_value_one == $past(dc_reg))
      else $error("duty not loaded on tick");
   a_iue_load: assert property (con_reg[2] && !con_reg[0] && wr && paddr == mpfo_pkg::OFS_DC1
      |-> ##[1:2] duty_value_one == dc_reg)
      else $error("immediate duty update missing");
   a_high_follow: assert property (s_calm |=> high_side_output[0] == $past(exp_h))
      else $error("high pin 1 wrong source");
   a_low_follow: assert property (s_calm |=> low_side_output[2] == $past(exp_l))
      else $error("low pin 3 wrong source");
endmodule : mpfo_top_props
bind mpfo_top mpfo_top_props i_mpfo_top_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .write_lock_config(write_lock_config),
   .time_base_tick(time_base_tick), .gen_high(gen_high), .gen_low(gen_low),
   .fault_a_input_pin_n(fault_a_input_pin_n), .fault_b_input_pin_n(fault_b_input_pin_n),
   .high_side_output(high_side_output), .low_side_output(low_side_output),
   .duty_value_one(duty_value_one));

// >>> verif/mpfo_fault_model.sv
`timescale 1ns/100ps
module mpfo_fault_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic trip_a,
   input  wire logic trip_b,
   output logic      fault_a_input_pin_n,
   output logic      fault_b_input_pin_n
);
   // Sense lines are pulled up, so a quiet sensor reads inactive high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_a_input_pin_n <= 1'b1;
         fault_b_input_pin_n <= 1'b1;
      end else begin
         fault_a_input_pin_n <= !trip_a;
         fault_b_input_pin_n <= !trip_b;
      end
   end
endmodule : mpfo_fault_model

// >>> verif/mpfo_top_tb.sv
`timescale 1ns/100ps
module mpfo_top_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
   logic        write_lock_config, time_base_tick, trip_a, trip_b, fa_n, fb_n;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  gen_high, gen_low, hso, lso;
   logic [15:0] dv1, dv2, dv3;
   int          n_errors, comparisons;
   logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
   logic [15:0] rv [6] = '{16'h0000, 16'h0007, 16'h0007, 16'h3F00, 16'h0000, 16'h0000};
   logic [15:0] ov [3] = '{16'h0015, 16'h002A, 16'h3F00};
   logic [15:0] fa [3] = '{16'h0A07, 16'h0181, 16'h0000};
   logic [15:0] fb [3] = '{16'h0000, 16'h0000, 16'h1405};
   logic [2:0]  eh [6] = '{3'h0, 3'h7, 3'h5, 3'h3, 3'h4, 3'h0};
   logic [2:0]  el [6] = '{3'h7, 3'h0, 3'h2, 3'h0, 3'h3, 3'h6};
   mpfo_top i_mpfo_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .write_lock_config(write_lock_config), .time_base_tick(time_base_tick),
      .gen_high(gen_high), .gen_low(gen_low), .fault_a_input_pin_n(fa_n),
      .fault_b_input_pin_n(fb_n), .high_side_output(hso), .low_side_output(lso),
      .duty_value_one(dv1), .duty_value_two(dv2), .duty_value_three(dv3));
   mpfo_fault_model i_mpfo_fault_model (.pclk(pclk), .presetn(presetn), .trip_a(trip_a),
      .trip_b(trip_b), .fault_a_input_pin_n(fa_n), .fault_b_input_pin_n(fb_n));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      #100000;
      n_errors++;
      finish_test();
   end
   // =========
   // Tasks
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge pclk);
      if (n == 16) begin
         n_errors++;
         $display("Error at %0t: pready got %h expected %h", $time, pready, 1'b1);
      end
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      xfer(1'b1, a, {16'h0000, d});
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rd, {16'h0000, e});
   endtask : rdchk
   task automatic tick();
      @(posedge pclk);
      time_base_tick <= 1'b1;
      @(posedge pclk);
      time_base_tick <= 1'b0;
      // Let the tick's effect settle before anyone samples the outputs
      @(posedge pclk);
   endtask : tick
   task automatic pins(input int i);
      repeat (4) @(posedge pclk);
      chk({26'h0, hso, lso}, {26'h0, eh[i], el[i]});
   endtask : pins
   task automatic finish_test();
      $display("Counts: %0d comparisons, %0d errors", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   // =========
   // Sequence
   initial begin
      {presetn, psel, penable, pwrite, write_lock_config, time_base_tick, trip_a, trip_b} = 8'h00;
      {paddr, pwdata, gen_high, gen_low} = {8'h00, 32'h0, 3'h5, 3'h2};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) rdchk(ra[i], rv[i]);
      $display("Test reset values done");
      xfer(1'b1, 8'h10, 32'hFFFF_FFFF);
      wr(8'h14, 16'hA5A5);
      wr(8'h18, 16'h0F0F);
      rdchk(8'h10, 16'hFFFF);
      rdchk(8'h14, 16'hA5A5);
      rdchk(8'h18, 16'h0F0F);
      $display("Test duty registers done");
      wr(8'h04, 16'h0000);
      rdchk(8'h04, 16'h0000);
      tick();
      for (int i = 0; i < 3; i++) begin
         wr(8'h0C, ov[i]);
         pins(i);
      end
      $display("Test manual override done");
      for (int i = 0; i < 3; i++) begin
         wr(8'h04, fa[i]);
         wr(8'h08, fb[i]);
         trip_a <= (i < 2);
         trip_b <= (i == 2);
         pins(i + 3);
         trip_a <= 1'b0;
         trip_b <= 1'b0;
         if (i == 0) pins(3);
         tick();
         pins(2);
      end
      $display("Test faults done");
      write_lock_config <= 1'b1;
      wr(8'h04, 16'h0003);
      rdchk(8'h04, 16'h0000);
      wr(8'h1C, mpfo_pkg::KEY_FIRST);
      wr(8'h10, 16'h1234);
      wr(8'h1C, mpfo_pkg::KEY_SECOND);
      wr(8'h04, 16'h0003);
      rdchk(8'h04, 16'h0000);
      wr(8'h1C, mpfo_pkg::KEY_FIRST);
      wr(8'h1C, mpfo_pkg::KEY_SECOND);
      wr(8'h04, 16'h0003);
      rdchk(8'h04, 16'h0003);
      write_lock_config <= 1'b0;
      $display("Test write lock done");
      chk({16'h0, dv1}, 32'h0000_FFFF);
      tick();
      chk({16'h0, dv1}, 32'h0000_1234);
      chk({16'h0, dv2}, 32'h0000_A5A5);
      chk({16'h0, dv3}, 32'h0000_0F0F);
      rdchk(8'h20, 16'h1234);
      wr(8'h00, 16'h0001);
      wr(8'h10, 16'h5678);
      tick();
      chk({16'h0, dv1}, 32'h0000_1234);
      wr(8'h00, 16'h0004);
      wr(8'h10, 16'h9ABC);
      repeat (2) @(posedge pclk);
      chk({16'h0, dv1}, 32'h0000_9ABC);
      $display("Test duty update done");
      wr(8'h00, 16'h0002);
      wr(8'h0C, 16'h0015);
      pins(2);
      tick();
      pins(0);
      rdchk(8'h30, 16'h0000);
      chk({31'h0, last_err}, 32'h1);
      $display("Test sync and unmapped done");
      finish_test();
   end
endmodule : mpfo_top_tb
